// ===== stc_core.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Select low full step, high half step.
// - Reset loads home levels and mixed decay.
// - Each step rising edge with reset high advances one increment.
// - Lower new level selects mixed decay.
// - Higher or equal level selects slow decay.
// - Reset low holds home, outputs off.
// - Direction low clockwise, high counterclockwise.
// - Direction sampled only at step edge.
// - On period drives one diagonal pair.
// - Per-bridge latch reset by sense comparator.
// - Slow drops source, mixed first drives the reverse diagonal.
// - Trip level is limit times step percent.
// - Off interval one-shot, then new on period.
// - Mixed decay fast for first 31.25 percent.
// - Output disable blanks bridges, translator runs.
// - Comparators masked 1us after switching.
module stc_core #(
  parameter int unsigned P_OFF_RES_US = 30  // Off interval set by the timing resistor.
) (
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // Translator pins.
  input  wire logic        i_step,
  input  wire logic        i_dir,
  input  wire logic        i_step_resolution_select,
  input  wire logic        i_reset_n,
  input  wire logic        i_out_disable,
  // Chopper pins.
  input  wire logic        i_off_time_set_input,
  input  wire logic        i_phase_one_sense_input,
  input  wire logic        i_phase_two_sense_input,
  // Phase trip levels and state, index 0 is phase one.
  output logic      [13:0] o_p1_trip_pct,
  output logic      [13:0] o_p2_trip_pct,
  output logic      [1:0]  o_polarity,
  output logic      [1:0]  o_mixed_decay,
  // Bridge switches, index 0 is bridge one.
  output logic      [1:0]  o_src_a,
  output logic      [1:0]  o_snk_a,
  output logic      [1:0]  o_src_b,
  output logic      [1:0]  o_snk_b
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  logic       rst_s1_q;   // First reset release stage.
  logic       rst_n;      // Released reset used by the design.
  logic [7:0] pin_s1_q;   // First stage of pin synchronisers.
  logic [7:0] pin_s2_q;   // Second stage, the only stage logic reads.
  logic       step_d1_q;  // Delayed step for edge detection.

  // Reset is asserted at once and released after two edges.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Every pin passes two flip-flops before use.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q  <= 8'h00;
      pin_s2_q  <= 8'h00;
      step_d1_q <= 1'b0;
    end else begin
      pin_s1_q  <= {i_phase_two_sense_input, i_phase_one_sense_input,
                    i_off_time_set_input, i_out_disable, i_reset_n,
                    i_step_resolution_select, i_dir, i_step};
      pin_s2_q  <= pin_s1_q;
      step_d1_q <= pin_s2_q[0];
    end
  end

  logic       step_s;     // Synchronised step.
  logic       dir_s;      // Synchronised direction.
  logic       half_s;     // High selects half step.
  logic       hold;       // Translator reset pin is low.
  logic       dis_s;      // Outputs disabled.
  logic       off_def_s;  // High selects default off interval.
  logic [1:0] sense_s;    // Sense comparator outputs per phase.
  logic       step_rise;  // One-cycle step rising edge.
  logic       step_acc;   // Step edge that the translator takes.

  assign step_s    = pin_s2_q[0];
  assign dir_s     = pin_s2_q[1];
  assign half_s    = pin_s2_q[2];
  assign hold      = !pin_s2_q[3];
  assign dis_s     = pin_s2_q[4];
  assign off_def_s = pin_s2_q[5];
  assign sense_s   = pin_s2_q[7:6];
  assign step_rise = step_s && !step_d1_q;
  assign step_acc  = step_rise && !hold;

  ////////////////////////////////////////////////////////////////////////////////
  // Translator.

  // Level code of a phase at a table index.
  function automatic logic [1:0] lvl_of(input logic [2:0] idx, input logic ph);
    logic [2:0] k;
    k = ph ? idx - 3'h2 : idx;
    if (idx[0]) lvl_of = stc_pkg::LVL_MID;
    else if (k[1]) lvl_of = stc_pkg::LVL_ZERO;
    else lvl_of = stc_pkg::LVL_FULL;
  endfunction

  // Current sign of a phase at a table index, high for positive.
  function automatic logic pos_of(input logic [2:0] idx, input logic ph);
    logic [2:0] k;
    k = ph ? idx - 3'h2 : idx;
    pos_of = !(k == 3'h3 || k == 3'h4 || k == 3'h5);
  endfunction

  logic [2:0] idx_q, idx_d;      // Table position.
  logic [1:0] lvl_q [2];         // Phase level codes.
  logic [1:0] lvl_d [2];
  logic [1:0] pos_q, pos_d;      // Phase polarities.
  logic [1:0] mixed_q, mixed_d;  // Phase decay, high for mixed.
  logic [2:0] inc;               // Increment of this step.

  // Next translator state from step, direction and resolution.
  always_comb begin
    // Full step from an axis entry moves one to reach a diagonal.
    inc     = (half_s || !idx_q[0]) ? 3'h1 : 3'h2;
    idx_d   = idx_q;
    pos_d   = pos_q;
    mixed_d = mixed_q;
    lvl_d   = lvl_q;
    if (hold) begin
      idx_d   = stc_pkg::HOME_IDX;
      mixed_d = 2'b11;
    end else if (step_acc) begin
      idx_d = dir_s ? idx_q + inc : idx_q - inc;
    end
    for (int p = 0; p < 2; p++) begin
      if (hold || step_acc) begin
        lvl_d[p] = lvl_of(idx_d, p[0]);
        pos_d[p] = pos_of(idx_d, p[0]);
      end
      if (step_acc) begin
        mixed_d[p] = lvl_d[p] < lvl_q[p];
      end
    end
  end

  // Translator registers load home at reset.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q    <= stc_pkg::HOME_IDX;
      lvl_q[0] <= stc_pkg::LVL_MID;
      lvl_q[1] <= stc_pkg::LVL_MID;
      pos_q    <= 2'b11;
      mixed_q  <= 2'b11;
    end else begin
      idx_q   <= idx_d;
      lvl_q   <= lvl_d;
      pos_q   <= pos_d;
      mixed_q <= mixed_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Chopper, one per bridge.

  logic [stc_pkg::CNT_W-1:0]    off_cyc;   // Off interval in cycles.
  logic [stc_pkg::CNT_W-1:0]    fast_cyc;  // Fast part of a mixed interval.
  logic [stc_pkg::CNT_W+2:0]    fast_w;    // Wide product for the fast part.
  logic [3:0]                   gate [2];  // Wanted switch states per bridge.
  stc_pkg::stc_chop_t           st_mon;    // Bridge one state, for checking.
  localparam logic [stc_pkg::CNT_W-1:0] OFF_RES_CYC =
    stc_pkg::CNT_W'(P_OFF_RES_US * 1000 / stc_pkg::CLK_PERIOD_NS);

  assign off_cyc  = off_def_s ? stc_pkg::CNT_W'(stc_pkg::OFF_DEF_CYC) : OFF_RES_CYC;
  assign fast_w   = (stc_pkg::CNT_W+3)'(off_cyc) * (stc_pkg::CNT_W+3)'(stc_pkg::FAST_NUM);
  assign fast_cyc = stc_pkg::CNT_W'(fast_w >> stc_pkg::FAST_SHIFT);

  for (genvar p = 0; p < 2; p++) begin : g_phase
    stc_pkg::stc_chop_t        st_q, st_d;    // Latch state.
    logic [stc_pkg::CNT_W-1:0] cnt_q, cnt_d;  // Off interval count.
    logic [stc_pkg::BLK_W-1:0] blk_q, blk_d;  // Mask count.
    logic                      trip;          // Comparator reached trip level.

    // A trip counts only when the mask has run out.
    assign trip = sense_s[p] && (blk_q == '0);

    // Next latch state, off count and mask count.
    always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      blk_d = (blk_q != '0) ? blk_q - 1'b1 : blk_q;
      if (hold) begin
        st_d  = stc_pkg::CH_ON;
        blk_d = stc_pkg::BLK_W'(stc_pkg::BLANK_CYC - 1);
      end else begin
        case (st_q)
          stc_pkg::CH_ON: begin
            if (trip) begin
              st_d  = mixed_q[p] ? stc_pkg::CH_FAST : stc_pkg::CH_SLOW;
              cnt_d = '0;
            end
          end
          stc_pkg::CH_FAST: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_d >= fast_cyc) st_d = stc_pkg::CH_SLOW;
          end
          stc_pkg::CH_SLOW: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_d >= off_cyc) begin
              st_d  = stc_pkg::CH_ON;
              blk_d = stc_pkg::BLK_W'(stc_pkg::BLANK_CYC - 1);
            end
          end
          default: st_d = stc_pkg::CH_ON;
        endcase
      end
    end

    // Latch state registers.
    always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
        st_q  <= stc_pkg::CH_ON;
        cnt_q <= '0;
        blk_q <= stc_pkg::BLK_W'(stc_pkg::BLANK_CYC - 1);
      end else begin
        st_q  <= st_d;
        cnt_q <= cnt_d;
        blk_q <= blk_d;
      end
    end

    // Switch pattern: diagonal on, reverse diagonal in fast, both sinks in slow.
    always_comb begin
      gate[p] = 4'h0;
      case (st_q)
        stc_pkg::CH_ON: begin
          gate[p][pos_q[p] ? stc_pkg::G_SRC_A : stc_pkg::G_SRC_B] = 1'b1;
          gate[p][pos_q[p] ? stc_pkg::G_SNK_B : stc_pkg::G_SNK_A] = 1'b1;
        end
        stc_pkg::CH_FAST: begin
          gate[p][pos_q[p] ? stc_pkg::G_SRC_B : stc_pkg::G_SRC_A] = 1'b1;
          gate[p][pos_q[p] ? stc_pkg::G_SNK_A : stc_pkg::G_SNK_B] = 1'b1;
        end
        stc_pkg::CH_SLOW: begin
          gate[p][stc_pkg::G_SNK_A] = 1'b1;
          gate[p][stc_pkg::G_SNK_B] = 1'b1;
        end
        default: gate[p] = 4'h0;
      endcase
      if (hold || dis_s) gate[p] = 4'h0;
    end
  end

  assign st_mon = g_phase[0].st_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Output stage.

  // Trip level of a level code.
  function automatic logic [13:0] pct_of(input logic [1:0] l);
    case (l)
      stc_pkg::LVL_FULL: pct_of = stc_pkg::PCT_FULL;
      stc_pkg::LVL_MID:  pct_of = stc_pkg::PCT_MID;
      default:           pct_of = stc_pkg::PCT_ZERO;
    endcase
  endfunction

  // Every output is registered; bridges start off.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_p1_trip_pct <= stc_pkg::PCT_MID;
      o_p2_trip_pct <= stc_pkg::PCT_MID;
      o_polarity    <= 2'b11;
      o_mixed_decay <= 2'b11;
      o_src_a       <= 2'b00;
      o_snk_a       <= 2'b00;
      o_src_b       <= 2'b00;
      o_snk_b       <= 2'b00;
    end else begin
      o_p1_trip_pct <= pct_of(lvl_q[0]);
      o_p2_trip_pct <= pct_of(lvl_q[1]);
      o_polarity    <= pos_q;
      o_mixed_decay <= mixed_q;
      o_src_a       <= {gate[1][stc_pkg::G_SRC_A], gate[0][stc_pkg::G_SRC_A]};
      o_snk_a       <= {gate[1][stc_pkg::G_SNK_A], gate[0][stc_pkg::G_SNK_A]};
      o_src_b       <= {gate[1][stc_pkg::G_SRC_B], gate[0][stc_pkg::G_SRC_B]};
      o_snk_b       <= {gate[1][stc_pkg::G_SNK_B], gate[0][stc_pkg::G_SNK_B]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_home_on_reset: assert property (@(posedge i_mclk) disable iff (!rst_n)
    hold |=> idx_q == stc_pkg::HOME_IDX && mixed_q == 2'b11)
    else $error("Translator not at home during reset.");
  a_reset_outputs_off: assert property (@(posedge i_mclk) disable iff (!rst_n)
    hold ##1 hold |=> (o_src_a | o_src_b | o_snk_a | o_snk_b) == 2'b00)
    else $error("Bridges driven during reset.");
  a_half_ccw: assert property (@(posedge i_mclk) disable iff (!rst_n)
    step_acc && dir_s && half_s |=> idx_q == $past(idx_q) + 3'h1)
    else $error("Half step counterclockwise wrong.");
  a_half_cw: assert property (@(posedge i_mclk) disable iff (!rst_n)
    step_acc && !dir_s && half_s |=> idx_q == $past(idx_q) - 3'h1)
    else $error("Half step clockwise wrong.");
  a_full_diag: assert property (@(posedge i_mclk) disable iff (!rst_n)
    step_acc && !half_s |=> idx_q[0])
    else $error("Full step left a diagonal entry.");
  a_decay_choice: assert property (@(posedge i_mclk) disable iff (!rst_n)
    step_acc |=> mixed_q[0] == (lvl_q[0] < $past(lvl_q[0])))
    else $error("Phase one decay choice wrong.");
  a_decay_held: assert property (@(posedge i_mclk) disable iff (!rst_n)
    !step_acc && !hold |=> $stable(mixed_q) && $stable(idx_q))
    else $error("Translator moved without a step.");
  a_disable_off: assert property (@(posedge i_mclk) disable iff (!rst_n)
    dis_s |=> (o_src_a | o_src_b | o_snk_a | o_snk_b) == 2'b00)
    else $error("Bridges driven while disabled.");
  a_blank_mask: assert property (@(posedge i_mclk) disable iff (!rst_n)
    st_mon == stc_pkg::CH_ON && g_phase[0].blk_q != '0 |=> st_mon == stc_pkg::CH_ON)
    else $error("Trip taken inside mask interval.");
  a_off_no_source: assert property (@(posedge i_mclk) disable iff (!rst_n)
    st_mon == stc_pkg::CH_SLOW |=> !o_src_a[0] && !o_src_b[0])
    else $error("Source on during slow decay.");
  a_on_diagonal: assert property (@(posedge i_mclk) disable iff (!rst_n)
    st_mon == stc_pkg::CH_ON && !hold && !dis_s |=>
      o_src_a[0] == o_snk_b[0] && o_src_b[0] == o_snk_a[0] && o_src_a[0] != o_src_b[0])
    else $error("On period not a diagonal pair.");

endmodule // stc_core

// ===== stc_pkg.sv
package stc_pkg;
  // Clock and timing figures.
  localparam int unsigned CLK_PERIOD_NS = 25;    // 40 MHz master clock.
  localparam int unsigned T_BLANK_NS    = 1000;  // Comparator mask interval.
  localparam int unsigned BLANK_CYC     = T_BLANK_NS / CLK_PERIOD_NS;
  localparam int unsigned T_OFF_DEF_US  = 30;    // Fixed off interval with timing input high.
  localparam int unsigned OFF_DEF_CYC   = T_OFF_DEF_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned T_STEP_MIN_NS = 1000;  // Least step high and low width.
  localparam int unsigned STEP_MIN_CYC  =
    (T_STEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Fast part of a mixed off interval is 5/16, that is 31.25 percent.
  localparam int unsigned FAST_NUM   = 5;
  localparam int unsigned FAST_SHIFT = 4;
  // Counter widths.
  localparam int unsigned CNT_W = 12;
  localparam int unsigned BLK_W = 6;
  // Translator position index, eight half-step entries, home at 45 degrees.
  localparam logic [2:0] HOME_IDX = 3'h1;
  // Phase level codes and their trip levels in hundredths of a percent.
  localparam logic [1:0]  LVL_ZERO = 2'h0;
  localparam logic [1:0]  LVL_MID  = 2'h1;
  localparam logic [1:0]  LVL_FULL = 2'h2;
  localparam logic [13:0] PCT_ZERO = 14'h0000;
  localparam logic [13:0] PCT_MID  = 14'h1B9F;
  localparam logic [13:0] PCT_FULL = 14'h2710;
  // Bridge gate vector layout.
  localparam int unsigned G_SRC_A = 3;
  localparam int unsigned G_SNK_A = 2;
  localparam int unsigned G_SRC_B = 1;
  localparam int unsigned G_SNK_B = 0;
  // Chopper states.
  typedef enum logic [1:0] {
    CH_ON   = 2'b00,
    CH_FAST = 2'b01,
    CH_SLOW = 2'b10
  } stc_chop_t;
endpackage

// ===== stc_step_ctl.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Controller model: gives step pulses of legal width and holds direction and select.
module stc_step_ctl (
  // Clock.
  input  wire logic i_mclk,
  // Pins towards the block.
  output logic      o_step,
  output logic      o_dir,
  output logic      o_sel
);
  // Pins start idle, step low as the block needs after reset.
  initial begin
    o_step = 1'b0;
    o_dir  = 1'b0;
    o_sel  = 1'b1;
  end

  // Changes the direction level alone, with no step edge.
  task automatic set_dir(input logic dir);
    @(negedge i_mclk);
    o_dir = dir;
  endtask

  // One step: level inputs settle 200 ns ahead, then high and low for 1 us each.
  task automatic pulse(input logic dir, input logic sel);
    @(negedge i_mclk);
    o_dir = dir;
    o_sel = sel;
    repeat (8) @(negedge i_mclk);
    o_step = 1'b1;
    repeat (40) @(negedge i_mclk);
    o_step = 1'b0;
    repeat (40) @(negedge i_mclk);
  endtask
endmodule // stc_step_ctl

// ===== test_stepper_translator_chopper.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: steps the translator and measures the chopper phases.
module test_stepper_translator_chopper;
  logic        i_mclk;          // Master clock.
  logic        i_arst_n;        // Power-on reset.
  logic        i_reset_n;       // Translator reset pin.
  logic        i_out_disable;   // Output disable pin.
  logic [1:0]  sns;             // Sense comparators, bit0 is phase one.
  logic        ost;             // Timing input, high picks the default off interval.
  logic        step, dir, sel;  // Driven by the controller model.
  logic [13:0] p1, p2;          // Trip levels.
  logic [1:0]  pol, mix;        // Polarity and decay per phase.
  logic [1:0]  sa, ka, sb, kb;  // Bridge switches.
  int          idx;             // Expected table index.
  int          bad_count;       // Mismatches.
  int          checks;          // Comparisons made.

  // Clock at 40 MHz.
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  stc_step_ctl ctl (.i_mclk(i_mclk), .o_step(step), .o_dir(dir), .o_sel(sel));

  // Short off interval of 2 us keeps the chopper runs brief.
  localparam int OFF_US      = 2;
  localparam int OFF_RES_CYC = OFF_US * 1000 / stc_pkg::CLK_PERIOD_NS;
  stc_core #(.P_OFF_RES_US(OFF_US)) DUT (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_step(step), .i_dir(dir),
    .i_step_resolution_select(sel), .i_reset_n(i_reset_n),
    .i_out_disable(i_out_disable), .i_off_time_set_input(ost),
    .i_phase_one_sense_input(sns[0]), .i_phase_two_sense_input(sns[1]),
    .o_p1_trip_pct(p1), .o_p2_trip_pct(p2), .o_polarity(pol), .o_mixed_decay(mix),
    .o_src_a(sa), .o_snk_a(ka), .o_src_b(sb), .o_snk_b(kb));

  ////////////////////////////////////////////////////////////////////////////////
  // Level code of phase one at an index: 2 full, 1 mid, 0 zero.
  function automatic int code(int i);
    return ((i & 7) % 2 == 1) ? 1 : (((i & 7) % 4 == 0) ? 2 : 0);
  endfunction

  // Phase one current is positive at 315, 0 and 45 degrees.
  function automatic logic pos(int i);
    return ((i & 7) == 7) || ((i & 7) <= 1);
  endfunction

  // Trip level in hundredths of a percent for a level code.
  function automatic logic [13:0] pctv(int c);
    return (c == 2) ? stc_pkg::PCT_FULL : ((c == 1) ? stc_pkg::PCT_MID : stc_pkg::PCT_ZERO);
  endfunction

  // Switch pattern {src_a, snk_a, src_b, snk_b} of one bridge.
  function automatic logic [3:0] sw(int b);
    return {sa[b], ka[b], sb[b], kb[b]};
  endfunction

  // Exact comparison of a design value.
  task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Range comparison of a measured cycle count.
  task automatic rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // Waits, bounded, until a bridge shows a pattern.
  task automatic waitpat(input int b, input logic [3:0] pat);
    int n;
    n = 0;
    while (sw(b) !== pat && n < 3000) begin
      @(negedge i_mclk);
      n++;
    end
    rng(n, 0, 2999);
  endtask

  // Counts the cycles a bridge holds a pattern.
  task automatic seglen(input int b, input logic [3:0] pat, output int n);
    n = 0;
    while (sw(b) === pat && n < 3000) begin
      @(negedge i_mclk);
      n++;
    end
  endtask

  // One step and the expected levels, polarities and decay modes.
  task automatic step1(input logic d, input logic s);
    int o1, o2, n;
    o1 = code(idx);
    o2 = code(idx + 6);
    ctl.pulse(d, s);
    n = (s || (idx % 2 == 1)) ? (s ? 1 : 2) : 1;
    idx = (idx + (d ? n : 8 - n)) % 8;
    cmp(p1, pctv(code(idx)));
    cmp(p2, pctv(code(idx + 6)));
    cmp(mix, {code(idx + 6) < o2, code(idx) < o1});
    if (code(idx) != 0) cmp(pol[0], pos(idx));
    if (code(idx + 6) != 0) cmp(pol[1], pos(idx + 6));
  endtask

  // Holds a sense input high and times on, fast and slow parts of an off interval.
  // With sense held high the on period lasts exactly the mask interval.
  task automatic chop(input int b, input logic m, input int off);
    int n, f;
    f = off * 3125 / 10000;  // Fast part is 31.25 percent of the off interval.
    sns[b] = 1'b1;
    waitpat(b, 4'h5);
    waitpat(b, 4'h9);
    seglen(b, 4'h9, n);
    rng(n, stc_pkg::BLANK_CYC, stc_pkg::BLANK_CYC + 1);
    if (m) begin
      seglen(b, 4'h6, n);
      rng(n, f - 1, f + 1);
    end
    seglen(b, 4'h5, n);
    rng(n, (m ? off - f : off) - 1, (m ? off - f : off) + 1);
    cmp(sw(b), 4'h9);
    sns[b] = 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog well past the expected run of about 5600 cycles.
  initial begin
    repeat (30000) @(posedge i_mclk);
    bad_count++;
    finish_test;
  end

  // Main sequence.
  initial begin
    bad_count = 0;
    checks = 0;
    i_arst_n = 1'b0;
    i_reset_n = 1'b1;
    i_out_disable = 1'b0;
    sns = 2'h0;
    ost = 1'b0;
    idx = 1;
    repeat (10) @(negedge i_mclk);
    cmp({sa, ka, sb, kb}, 8'h00);
    i_arst_n = 1'b1;
    repeat (6) @(negedge i_mclk);
    cmp(p1, stc_pkg::PCT_MID);
    cmp({pol, mix}, 4'hF);
    chop(0, 1'b1, OFF_RES_CYC);
    // Half steps both ways, then a slow-decay bridge, then full steps.
    for (int k = 0; k < 8; k++) step1(1'b1, 1'b1);
    for (int k = 0; k < 8; k++) step1(1'b0, 1'b1);
    step1(1'b1, 1'b1);
    chop(1, 1'b0, OFF_RES_CYC);
    // Timing input high selects the default off interval.
    ost = 1'b1;
    repeat (4) @(negedge i_mclk);
    chop(1, 1'b0, stc_pkg::OFF_DEF_CYC);
    ost = 1'b0;
    for (int k = 0; k < 5; k++) step1(1'b1, 1'b0);
    for (int k = 0; k < 4; k++) step1(1'b0, 1'b0);
    // A direction change alone moves nothing.
    ctl.set_dir(1'b1);
    repeat (20) @(negedge i_mclk);
    cmp(p1, pctv(code(idx)));
    cmp(p2, pctv(code(idx + 6)));
    // Disabled outputs stay off while the translator keeps stepping.
    i_out_disable = 1'b1;
    step1(1'b1, 1'b1);
    cmp({sa, ka, sb, kb}, 8'h00);
    i_out_disable = 1'b0;
    // Translator reset holds home and drops steps.
    i_reset_n = 1'b0;
    repeat (5) @(negedge i_mclk);
    ctl.pulse(1'b1, 1'b1);
    cmp(p1, stc_pkg::PCT_MID);
    cmp(p2, stc_pkg::PCT_MID);
    cmp({mix, sa, ka, sb, kb}, 10'h300);
    i_reset_n = 1'b1;
    idx = 1;
    repeat (6) @(negedge i_mclk);
    step1(1'b1, 1'b1);
    finish_test;
  end
endmodule // test_stepper_translator_chopper
